// >>> shared/rsu_pkg.sv
`default_nettype none
package rsu_pkg;
   localparam int ADDR_W = 10;
   localparam int NCH = 30;
   localparam logic [4:0] NCH_T1 = 5'h18;
   localparam logic [4:0] NCH_E1 = 5'h1e;
   localparam logic [29:0] CHMASK_T1 = 30'h00ffffff;
   localparam logic [29:0] CHMASK_E1 = 30'h3fffffff;
   // register indices, byte address is four times the index
   localparam logic [7:0] IDX_INFO = 8'h38;
   localparam logic [7:0] IDX_CSE = 8'h3c;
   localparam logic [7:0] IDX_SIGNALING_CONTROL = 8'h40;
   localparam logic [7:0] IDX_RS = 8'h60;
   localparam logic [7:0] IDX_STATUS = 8'h80;
   localparam logic [7:0] IDX_IMR = 8'h81;
   localparam logic [7:0] IDX_CCR = 8'h82;
   localparam logic [7:0] IDX_MODE = 8'h83;
   localparam logic [7:0] IDX_PER_CHAN_POINTER = 8'h84;
   localparam logic [7:0] IDX_PCDR = 8'h88;
   // field positions
   localparam int SIGNALING_CONTROL_ONES = 0;
   localparam int SIGNALING_CONTROL_TXORD = 1;
   localparam int SIGNALING_CONTROL_RXORD = 2;
   localparam int SIGNALING_CONTROL_FRZ_FORCE = 3;
   localparam int SIGNALING_CONTROL_FRZ_EN = 4;
   localparam int SIGNALING_CONTROL_GREINS = 7;
   localparam logic [7:0] SIGNALING_CONTROL_WMASK = 8'h9f;
   localparam int STAT_COS = 5;
   localparam int IMR_COS = 5;
   localparam int CCR_INTEG = 5;
   localparam int MODE_T1 = 0;
   localparam int MODE_D4 = 1;
   localparam int MODE_ES = 2;
   localparam int MODE_BP2M = 3;
   localparam int PER_CHAN_POINTER_REINS = 0;
   localparam int PER_CHAN_POINTER_ONES = 1;
   // reset values
   localparam logic [7:0] SIGNALING_CONTROL_RST = 8'h00;
   localparam logic [7:0] MODE_RST = 8'h00;
   // backplane framing
   localparam logic [7:0] LAST_BIT_T1 = 8'hc0;
   localparam logic [7:0] LAST_BIT_2M = 8'hff;
   localparam logic [4:0] LAST_MF_ESF = 5'h17;
   localparam logic [4:0] LAST_MF_D4 = 5'h0b;
   localparam logic [4:0] LAST_MF_E1 = 5'h0f;
   localparam logic [4:0] SLOT_TS16 = 5'h10;
   // freeze hold time after an error clears
   localparam int CLK_MHZ = 20;
   localparam int HOLD_ESF_US = 9000;
   localparam int HOLD_D4_US = 4500;
   localparam int HOLD_W = 18;
   localparam logic [HOLD_W-1:0] HOLD_ESF_CYC = HOLD_W'(HOLD_ESF_US * CLK_MHZ);
   localparam logic [HOLD_W-1:0] HOLD_D4_CYC = HOLD_W'(HOLD_D4_US * CLK_MHZ);
endpackage
`default_nettype wire

// >>> sim/rsu_backplane_model.sv
`timescale 1ns/100ps
`default_nettype none
module rsu_backplane_model #(
   parameter int BITS_PER_MF = 4096
) (
   // backplane pins
   output logic backplane_clk,
   output logic rx_frame_sync,
   output logic rx_serial_in
);
   int pos;
   initial begin
      backplane_clk = 1'b0;
      rx_frame_sync = 1'b0;
      rx_serial_in = 1'b0;
      pos = 0;
   end
   // free-running backplane clock at 2.5 MHz, a 400 ns period
   always #200 backplane_clk = ~backplane_clk;
   // sync marks bit 0 of frame 0, once per multiframe
   // data changes on every bit except those at multiples of eight, so a stale line never looks right
   always @(negedge backplane_clk) begin
      rx_frame_sync <= (pos == 0);
      rx_serial_in <= pos[0] ^ pos[3];
      pos <= (pos == BITS_PER_MF - 1) ? 0 : pos + 1;
   end
endmodule
`default_nettype wire

// >>> sim/test_receive_signaling_unit.sv
`timescale 1ns/100ps
`default_nettype none
module test_receive_signaling_unit import rsu_pkg::*;;
   logic mclk, rst, read, write, sig_valid, mf_boundary, oof;
   logic carrier_loss, frame_slip;
   logic [ADDR_W-1:0] address;
   logic [31:0] writedata, readdata, q;
   logic waitrequest, int_n, freeze_indicator;
   logic [4:0] sig_chan;
   logic [3:0] sig_abcd;
   logic backplane_clk, rx_frame_sync, rx_serial_in;
   logic sig_stream_out, rx_serial_out;
   int n_mismatch, n_compared;
   ////////////////////////////////////////////////////////////////////////
   // short hold counts keep the freeze run brief
   rsu_top #(.HOLD_ESF_CYCLES(18'h14), .HOLD_D4_CYCLES(18'h0a)) u_rsu_top (
      .mclk(mclk), .rst(rst), .address(address), .read(read),
      .write(write), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .sig_valid(sig_valid),
      .sig_chan(sig_chan), .sig_abcd(sig_abcd),
      .mf_boundary(mf_boundary), .oof(oof), .carrier_loss(carrier_loss),
      .frame_slip(frame_slip), .backplane_clk(backplane_clk),
      .rx_frame_sync(rx_frame_sync), .rx_serial_in(rx_serial_in),
      .sig_stream_out(sig_stream_out), .rx_serial_out(rx_serial_out),
      .freeze_indicator(freeze_indicator), .int_n(int_n));
   // a sync every second frame keeps the wait for a frame mark short
   rsu_backplane_model #(.BITS_PER_MF(512)) u_rsu_backplane_model (
      .backplane_clk(backplane_clk), .rx_frame_sync(rx_frame_sync),
      .rx_serial_in(rx_serial_in));
   always #25 mclk = ~mclk;
   ////////////////////////////////////////////////////////////////////////
   task cmp_reg(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t reg got %h exp %h", $time, got, exp);
      end
   endtask
   task cmp_pin(input logic got, input logic exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t pin got %b exp %b", $time, got, exp);
      end
   endtask
   // request held until waitrequest is seen low, then released
   task bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
      address <= {idx, 2'b00};
      read <= ~w;
      write <= w;
      writedata <= {24'h0, d};
      do begin
         @(posedge mclk);
      end while (waitrequest !== 1'b0);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
      @(posedge mclk);
   endtask
   task wr(input logic [7:0] idx, input logic [7:0] d);
      bus(1'b1, idx, d);
   endtask
   task rd(input logic [7:0] idx, input logic [7:0] exp);
      bus(1'b0, idx, 8'h00);
      cmp_reg(q, {24'h0, exp});
   endtask
   // one multiframe: every channel but index 1 gets v, channel index 1 gets ~v
   task send_mf(input logic [3:0] v);
      for (int ch = 0; ch < 30; ch++) begin
         sig_valid <= 1'b1;
         sig_chan <= ch[4:0];
         sig_abcd <= (ch == 1) ? ~v : v;
         @(posedge mclk);
      end
      sig_valid <= 1'b0;
      mf_boundary <= 1'b1;
      @(posedge mclk);
      mf_boundary <= 1'b0;
      repeat (3) @(posedge mclk);
   endtask
   // one sync period from the frame mark, sampled on the falling link edge
   // while the bit launched at the rise stands; t1m checks one T1 frame
   task chk_frame(input logic t1m, input logic [3:0] v, input logic ins);
      logic [8:0] j;
      logic [4:0] s;
      logic [2:0] b;
      logic [3:0] e;
      logic ev, ed;
      @(posedge backplane_clk iff rx_frame_sync);
      for (int i = 0; i < (t1m ? 193 : 512); i++) begin
         j = 9'(i);
         {s, b} = t1m ? 8'(i - 1) : j[7:0];
         e = (t1m || s != 5'h02) ? v : ~v;
         ev = b[2] && (t1m ? (i != 0) : (s != 5'h00 && s != SLOT_TS16));
         ev = ev ? e[~b[1:0]] : 1'b0;
         ed = (ins && j[8] && s == SLOT_TS16) ? v[~b[1:0]] : j[0] ^ j[3];
         @(negedge backplane_clk);
         cmp_pin(sig_stream_out, ev);
         cmp_pin(rx_serial_out, ed);
      end
      @(posedge mclk);
   endtask
   task finish_test;
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      // frame checks wait up to two sync periods each and dominate the run
      repeat (40000) @(posedge mclk);
      n_mismatch++;
      $display("[FAIL] %0t watchdog expired", $time);
      finish_test;
   end
   initial begin
      mclk = 1'b0;
      rst = 1'b1;
      {read, write, sig_valid, mf_boundary, oof} = 5'h00;
      {carrier_loss, frame_slip} = 2'h0;
      address = '0;
      writedata = 32'h0;
      sig_chan = 5'h00;
      sig_abcd = 4'h0;
      n_mismatch = 0;
      n_compared = 0;
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      rd(IDX_SIGNALING_CONTROL, 8'h00);
      wr(IDX_SIGNALING_CONTROL, 8'hff);
      rd(IDX_SIGNALING_CONTROL, 8'h9f);
      rd(8'h20, 8'h00);
      wr(IDX_PER_CHAN_POINTER, 8'h01);
      wr(IDX_PCDR, 8'h3c);
      rd(IDX_PCDR, 8'h3c);
      wr(IDX_PER_CHAN_POINTER, 8'h02);
      rd(IDX_PCDR, 8'h00);
      wr(IDX_SIGNALING_CONTROL, 8'h00);
      $display("test registers done");
      send_mf(4'h5);
      rd(IDX_RS, 8'h00);
      rd(IDX_RS + 8'h01, 8'ha5);
      wr(IDX_SIGNALING_CONTROL, 8'h04);
      rd(IDX_RS, 8'ha5);
      rd(IDX_INFO, 8'hff);
      rd(IDX_INFO + 8'h03, 8'h3f);
      rd(IDX_STATUS, 8'h00);
      rd(IDX_INFO, 8'h00);
      wr(IDX_CSE, 8'h01);
      wr(IDX_IMR, 8'h20);
      send_mf(4'h5);
      rd(IDX_STATUS, 8'h00);
      send_mf(4'h6);
      rd(IDX_STATUS, 8'h20);
      cmp_pin(int_n, 1'b0);
      wr(IDX_STATUS, 8'h20);
      rd(IDX_STATUS, 8'h00);
      repeat (3) @(posedge mclk);
      cmp_pin(int_n, 1'b1);
      $display("test change of state done");
      wr(IDX_CCR, 8'h20);
      send_mf(4'h9);
      rd(IDX_STATUS, 8'h00);
      repeat (3) send_mf(4'h9);
      rd(IDX_STATUS, 8'h20);
      wr(IDX_STATUS, 8'h20);
      $display("test integration done");
      oof <= 1'b1;
      repeat (5) @(posedge mclk);
      cmp_pin(freeze_indicator, 1'b0);
      wr(IDX_SIGNALING_CONTROL, 8'h10);
      repeat (5) @(posedge mclk);
      cmp_pin(freeze_indicator, 1'b1);
      oof <= 1'b0;
      repeat (10) @(posedge mclk);
      cmp_pin(freeze_indicator, 1'b1);
      repeat (50) @(posedge mclk);
      cmp_pin(freeze_indicator, 1'b0);
      frame_slip <= 1'b1;
      repeat (2) @(posedge mclk);
      cmp_pin(freeze_indicator, 1'b1);
      {frame_slip, carrier_loss} <= 2'b01;
      repeat (30) @(posedge mclk);
      cmp_pin(freeze_indicator, 1'b1);
      carrier_loss <= 1'b0;
      repeat (30) @(posedge mclk);
      cmp_pin(freeze_indicator, 1'b0);
      wr(IDX_SIGNALING_CONTROL, 8'h08);
      repeat (5) @(posedge mclk);
      cmp_pin(freeze_indicator, 1'b1);
      wr(IDX_SIGNALING_CONTROL, 8'h00);
      repeat (60) @(posedge mclk);
      cmp_pin(freeze_indicator, 1'b0);
      $display("test freeze done");
      wr(IDX_SIGNALING_CONTROL, 8'h80);
      repeat (3) send_mf(4'h3);
      chk_frame(1'b0, 4'h9, 1'b0);
      send_mf(4'h3);
      wr(IDX_MODE, 8'h04);
      wr(IDX_SIGNALING_CONTROL, 8'h81);
      chk_frame(1'b0, 4'h3, 1'b1);
      wr(IDX_MODE, 8'h01);
      chk_frame(1'b1, 4'hf, 1'b0);
      wr(IDX_MODE, 8'h03);
      send_mf(4'h9);
      rd(IDX_RS, 8'h5a);
      $display("test backplane done");
      finish_test;
   end
endmodule
`default_nettype wire

// >>> src/rsu_sigbuf.sv
`timescale 1ns/100ps
`default_nettype none
module rsu_sigbuf
   import rsu_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // one multiframe snapshot per write
   input wire logic wr_en,
   input wire logic [29:0][3:0] wr_data,
   // delayed read
   input wire logic [4:0] rd_ch,
   output logic [3:0] rd_abcd
);
   typedef struct packed {
      logic [3:0][29:0][3:0] mem;
      logic [1:0] wp;
   } rsu_buf_type;
   rsu_buf_type st_ff;
   rsu_buf_type nxt_st;

   always_comb begin
      nxt_st = st_ff;
      // a frozen buffer neither writes nor advances
      if (wr_en) begin
         nxt_st.mem[st_ff.wp] = wr_data;
         nxt_st.wp = st_ff.wp + 2'h1;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // slot at wp is the oldest of four, three multiframes behind the newest
   assign rd_abcd = (rd_ch < NCH_E1) ? st_ff.mem[st_ff.wp][rd_ch] : 4'h0;

   property p_buf_hold;
      @(posedge mclk) disable iff (rst) !wr_en |=> $stable(st_ff.mem);
   endproperty
   a_buf_hold: assert property (p_buf_hold) else $error("buffer moved while frozen");

   property p_buf_adv;
      @(posedge mclk) disable iff (rst)
         wr_en |=> st_ff.wp == $past(st_ff.wp) + 2'h1;
   endproperty
   a_buf_adv: assert property (p_buf_adv) else $error("write pointer stuck");
endmodule
`default_nettype wire

// >>> src/rsu_sync.sv
`timescale 1ns/100ps
`default_nettype none
module rsu_sync (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // pins and synchronised copies
   input wire logic [2:0] async_in,
   output logic [2:0] sync_out
);
   typedef struct packed {
      logic [2:0] s1;
      logic [2:0] s2;
   } rsu_sync_type;
   rsu_sync_type st_ff;
   rsu_sync_type nxt_st;

   always_comb begin
      nxt_st = st_ff;
      nxt_st.s1 = async_in;
      nxt_st.s2 = st_ff.s1;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign sync_out = st_ff.s2;
endmodule
`default_nettype wire

// >>> src/rsu_top.sv
// Local design decisions: the Avalon-MM register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module rsu_top
   import rsu_pkg::*;
#(
   parameter logic [HOLD_W-1:0] HOLD_ESF_CYCLES = HOLD_ESF_CYC,
   parameter logic [HOLD_W-1:0] HOLD_D4_CYCLES = HOLD_D4_CYC
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // avalon-mm slave
   input wire logic [ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   // framer side, same clock
   input wire logic sig_valid,
   input wire logic [4:0] sig_chan,
   input wire logic [3:0] sig_abcd,
   input wire logic mf_boundary,
   input wire logic oof,
   input wire logic carrier_loss,
   input wire logic frame_slip,
   // backplane pins
   input wire logic backplane_clk,
   input wire logic rx_frame_sync,
   input wire logic rx_serial_in,
   output logic sig_stream_out,
   output logic rx_serial_out,
   output logic freeze_indicator,
   output logic int_n
);
   typedef struct packed {
      logic wait_r;
      logic [31:0] rdata;
      logic [7:0] signaling_control;
      logic [7:0] mode;
      logic [7:0] imr;
      logic [7:0] ccr;
      logic [7:0] per_chan_pointer;
      logic status_cos;
      logic [29:0] cse;
      logic [29:0] info;
      logic [29:0] reins;
      logic [29:0] ones;
      logic [29:0][3:0] stage;
      logic [29:0][3:0] cur;
      logic [29:0][3:0] rep;
      logic [29:0][3:0] cand;
      logic [29:0][1:0] cnt;
      logic [HOLD_W-1:0] hold;
      logic frz;
      logic int_n;
      logic bclk_d;
      logic [7:0] bitpos;
      logic [4:0] frame;
      logic sig_out;
      logic ser_out;
   } rsu_state_type;
   rsu_state_type st_ff;
   rsu_state_type nxt_st;

   ////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] get_byte(input logic [29:0] m,
                                           input logic [1:0] k);
      logic [31:0] w;
      w = {2'h0, m};
      return w[{k, 3'h0} +: 8];
   endfunction

   function automatic logic [29:0] set_byte(input logic [29:0] m,
                                            input logic [1:0] k,
                                            input logic [7:0] v);
      logic [31:0] w;
      w = {2'h0, m};
      w[{k, 3'h0} +: 8] = v;
      return w[29:0];
   endfunction

   // cas order skips the spare word, ccs order packs channels from word 0
   function automatic logic [7:0] sig_word(input logic [29:0][3:0] r,
                                           input logic [3:0] n,
                                           input logic e1cas);
      logic [4:0] lo;
      lo = {n, 1'b0};
      if (e1cas) begin
         if (n == 4'h0) return 8'h00;
         lo = lo - 5'h02;
      end else if (n == 4'hf) begin
         return 8'h00;
      end
      return {r[lo + 5'h01], r[lo]};
   endfunction

   ////////////////////////////////////////////////////////////////////////
   logic [2:0] sync_s;
   logic bclk_s;
   logic fsync_s;
   logic rx_s;
   logic [3:0] rd_abcd;
   logic [4:0] rd_ch;
   logic wr_en;
   logic t1, d4, bp2m, ones_g, integ;
   logic [29:0] chmask, chg, clr_info;
   logic [7:0] idx, rd_val;
   logic req_new, acc, stat_clr, rd_info_hit;
   logic err_any, frozen_now;
   logic bclk_rise, fbit, chv, ts16, robbed, reins_ok, sb, sr, stable;
   logic [7:0] pos, off;
   logic [4:0] frm, slot, ch, rch;
   logic [2:0] bsel;
   logic [1:0] ltr;
   logic [3:0] v;

   rsu_sync u_sync (
      .mclk(mclk),
      .rst(rst),
      .async_in({rx_serial_in, rx_frame_sync, backplane_clk}),
      .sync_out(sync_s)
   );
   assign bclk_s = sync_s[0];
   assign fsync_s = sync_s[1];
   assign rx_s = sync_s[2];

   rsu_sigbuf u_buf (
      .mclk(mclk),
      .rst(rst),
      .wr_en(wr_en),
      .wr_data(st_ff.stage),
      .rd_ch(rd_ch),
      .rd_abcd(rd_abcd)
   );

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      nxt_st = st_ff;
      t1 = st_ff.mode[MODE_T1];
      d4 = t1 && st_ff.mode[MODE_D4];
      bp2m = st_ff.mode[MODE_BP2M];
      ones_g = t1 && st_ff.signaling_control[SIGNALING_CONTROL_ONES];
      integ = st_ff.ccr[CCR_INTEG];
      chmask = t1 ? CHMASK_T1 : CHMASK_E1;
      chg = 30'h0;
      v = 4'h0;
      stable = 1'b0;
      // bus: answer one cycle after the request is seen
      idx = address[ADDR_W-1:2];
      req_new = (read || write) && st_ff.wait_r;
      acc = (read || write) && !st_ff.wait_r;
      nxt_st.wait_r = !req_new;
      rd_val = 8'h00;
      if (idx[7:4] == IDX_RS[7:4]) begin
         rd_val = sig_word(st_ff.cur, idx[3:0],
                           !t1 && !st_ff.signaling_control[SIGNALING_CONTROL_RXORD]);
      end else if (idx[7:2] == IDX_INFO[7:2]) begin
         rd_val = get_byte(st_ff.info, idx[1:0]);
      end else if (idx[7:2] == IDX_CSE[7:2]) begin
         rd_val = get_byte(st_ff.cse, idx[1:0]);
      end else if (idx[7:2] == IDX_PCDR[7:2]) begin
         rd_val = get_byte(st_ff.per_chan_pointer[PER_CHAN_POINTER_REINS] ? st_ff.reins : st_ff.ones,
                           idx[1:0]);
      end else begin
         case (idx)
            IDX_SIGNALING_CONTROL: rd_val = st_ff.signaling_control;
            IDX_STATUS: rd_val = {2'h0, st_ff.status_cos, 5'h00};
            IDX_IMR: rd_val = st_ff.imr;
            IDX_CCR: rd_val = st_ff.ccr;
            IDX_MODE: rd_val = st_ff.mode;
            IDX_PER_CHAN_POINTER: rd_val = st_ff.per_chan_pointer;
            default: rd_val = 8'h00;
         endcase
      end
      if (req_new) begin
         nxt_st.rdata = read ? {24'h000000, rd_val} : 32'h0;
      end
      // only bits that were actually returned are cleared
      rd_info_hit = acc && read && (idx[7:2] == IDX_INFO[7:2]);
      clr_info = rd_info_hit ? set_byte(30'h0, idx[1:0], st_ff.rdata[7:0])
                             : 30'h0;
      stat_clr = acc && write && (idx == IDX_STATUS) &&
                 writedata[STAT_COS];
      if (acc && write) begin
         if (idx[7:2] == IDX_CSE[7:2]) begin
            nxt_st.cse = set_byte(st_ff.cse, idx[1:0], writedata[7:0]);
         end
         if (idx[7:2] == IDX_PCDR[7:2]) begin
            if (st_ff.per_chan_pointer[PER_CHAN_POINTER_REINS]) begin
               nxt_st.reins = set_byte(st_ff.reins, idx[1:0], writedata[7:0]);
            end
            if (st_ff.per_chan_pointer[PER_CHAN_POINTER_ONES]) begin
               nxt_st.ones = set_byte(st_ff.ones, idx[1:0], writedata[7:0]);
            end
         end
         case (idx)
            IDX_SIGNALING_CONTROL: nxt_st.signaling_control = writedata[7:0] & SIGNALING_CONTROL_WMASK;
            IDX_IMR: nxt_st.imr = writedata[7:0];
            IDX_CCR: nxt_st.ccr = writedata[7:0];
            IDX_MODE: nxt_st.mode = writedata[7:0];
            IDX_PER_CHAN_POINTER: nxt_st.per_chan_pointer = writedata[7:0];
            default: ;
         endcase
      end
      ////////////////////////////////////////////////////////////////////
      // capture into staging, published at the multiframe boundary
      if (sig_valid && sig_chan < (t1 ? NCH_T1 : NCH_E1)) begin
         nxt_st.stage[sig_chan] = d4 ? {sig_abcd[3:2], sig_abcd[3:2]}
                                     : sig_abcd;
      end
      if (mf_boundary) begin
         nxt_st.cur = st_ff.stage;
         for (int i = 0; i < NCH; i++) begin
            v = st_ff.stage[i];
            if (v != st_ff.cand[i]) begin
               nxt_st.cand[i] = v;
               nxt_st.cnt[i] = 2'h1;
            end else if (st_ff.cnt[i] != 2'h3) begin
               nxt_st.cnt[i] = st_ff.cnt[i] + 2'h1;
            end
            stable = !integ || (nxt_st.cnt[i] == 2'h3);
            if (stable && chmask[i] && (v != st_ff.rep[i])) begin
               chg[i] = 1'b1;
               nxt_st.rep[i] = v;
            end
         end
      end
      // set wins over a clear in the same cycle
      nxt_st.info = (st_ff.info & ~clr_info) | chg;
      nxt_st.status_cos = (st_ff.status_cos && !stat_clr) ||
                          (|(chg & st_ff.cse & chmask));
      nxt_st.int_n = !(st_ff.status_cos && st_ff.imr[IMR_COS]);
      ////////////////////////////////////////////////////////////////////
      // freeze and post-error hold
      err_any = oof || carrier_loss || frame_slip;
      if (err_any) begin
         nxt_st.hold = d4 ? HOLD_D4_CYCLES : HOLD_ESF_CYCLES;
      end else if (st_ff.hold != '0) begin
         nxt_st.hold = st_ff.hold - HOLD_W'(1);
      end
      frozen_now = st_ff.signaling_control[SIGNALING_CONTROL_FRZ_FORCE] ||
                   (st_ff.signaling_control[SIGNALING_CONTROL_FRZ_EN] &&
                    (err_any || st_ff.hold != '0));
      nxt_st.frz = frozen_now;
      wr_en = mf_boundary && !frozen_now;
      ////////////////////////////////////////////////////////////////////
      // backplane position, realigned by the external multiframe sync
      bclk_rise = bclk_s && !st_ff.bclk_d;
      nxt_st.bclk_d = bclk_s;
      pos = fsync_s ? 8'h00 : st_ff.bitpos;
      frm = fsync_s ? 5'h00 : st_ff.frame;
      fbit = t1 && !bp2m && (pos == 8'h00);
      off = (t1 && !bp2m) ? pos - 8'h01 : pos;
      slot = off[7:3];
      bsel = off[2:0];
      if (t1) begin
         chv = !fbit && (slot < NCH_T1);
         ch = slot;
      end else begin
         chv = (slot != 5'h00) && (slot != SLOT_TS16);
         ch = (slot < SLOT_TS16) ? slot - 5'h01 : slot - 5'h02;
      end
      ts16 = !t1 && (slot == SLOT_TS16) && (frm != 5'h00);
      rch = bsel[2] ? frm + 5'h0e : frm - 5'h01;
      rd_ch = ts16 ? rch : ch;
      robbed = t1 && chv && (bsel == 3'h7) &&
               (frm == 5'h05 || frm == 5'h0b || frm == 5'h11 ||
                frm == 5'h17);
      ltr = (frm == 5'h05) ? 2'h0 : (frm == 5'h0b) ? 2'h1 :
            (frm == 5'h11) ? 2'h2 : 2'h3;
      // elastic store off means no reinsertion at all
      reins_ok = st_ff.mode[MODE_ES] &&
                 (st_ff.signaling_control[SIGNALING_CONTROL_GREINS] || st_ff.reins[rd_ch]);
      // upper nibble carries nothing, low nibble carries ABCD or ABAB, or all ones when ones_g is set
      sb = 1'b0;
      if (chv && bsel[2]) begin
         sb = ones_g ? 1'b1 : rd_abcd[~bsel[1:0]];
      end
      sr = rx_s;
      if (robbed) begin
         if (st_ff.ones[ch] || ones_g) begin
            sr = 1'b1;
         end else if (reins_ok) begin
            sr = rd_abcd[~ltr];
         end
      end else if (ts16 && reins_ok) begin
         sr = rd_abcd[~bsel[1:0]];
      end
      if (bclk_rise) begin
         nxt_st.sig_out = sb;
         nxt_st.ser_out = sr;
         if (pos == ((t1 && !bp2m) ? LAST_BIT_T1 : LAST_BIT_2M)) begin
            nxt_st.bitpos = 8'h00;
            nxt_st.frame = (frm == (!t1 ? LAST_MF_E1 :
                                    d4 ? LAST_MF_D4 : LAST_MF_ESF))
                           ? 5'h00 : frm + 5'h01;
         end else begin
            nxt_st.bitpos = pos + 8'h01;
            nxt_st.frame = frm;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         st_ff <= '0;
         st_ff.wait_r <= 1'b1;
         st_ff.int_n <= 1'b1;
         st_ff.signaling_control <= SIGNALING_CONTROL_RST;
         st_ff.mode <= MODE_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign readdata = st_ff.rdata;
   assign waitrequest = st_ff.wait_r;
   assign sig_stream_out = st_ff.sig_out;
   assign rx_serial_out = st_ff.ser_out;
   assign freeze_indicator = st_ff.frz;
   assign int_n = st_ff.int_n;

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   property p_irq;
      1'b1 |=> st_ff.int_n ==
               !($past(st_ff.status_cos) && $past(st_ff.imr[IMR_COS]));
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt level wrong");

   property p_cos_flag;
      |(chg & st_ff.cse & chmask) |=> st_ff.status_cos;
   endproperty
   a_cos_flag: assert property (p_cos_flag) else $error("flag not set");

   property p_info_set;
      |chg |=> (st_ff.info & $past(chg)) == $past(chg);
   endproperty
   a_info_set: assert property (p_info_set) else $error("info not set");

   property p_info_clr;
      rd_info_hit && (chg == 30'h0) |=> (st_ff.info & $past(clr_info)) == 30'h0;
   endproperty
   a_info_clr: assert property (p_info_clr) else $error("info kept");

   property p_regs;
      !mf_boundary |=> $stable(st_ff.cur);
   endproperty
   a_regs: assert property (p_regs) else $error("registers moved");

   property p_force;
      st_ff.signaling_control[SIGNALING_CONTROL_FRZ_FORCE] |=> freeze_indicator;
   endproperty
   a_force: assert property (p_force) else $error("force freeze lost");

   sequence s_err_gone;
      st_ff.signaling_control[SIGNALING_CONTROL_FRZ_EN] && $fell(err_any);
   endsequence
   property p_hold;
      s_err_gone |-> ##1 (st_ff.frz || !st_ff.signaling_control[SIGNALING_CONTROL_FRZ_EN]) [*2];
   endproperty
   a_hold: assert property (p_hold) else $error("hold ended early");

   property p_ones;
      bclk_rise && ones_g && chv && bsel[2] |=> sig_stream_out;
   endproperty
   a_ones: assert property (p_ones) else $error("ones not forced");
endmodule
`default_nettype wire
